//--- hw/bbs_pkg.sv
// Package for the battery-backed SRAM host port: timing figures, cycle counts and carrier types.
// Assumes a 250 MHz system clock; all pin timings are derived from it here.
package bbs_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 4000;
  // Timing figures in their own units as printed.
  localparam int CYCLE_TIME_NS = 100;
  localparam int ADDRESS_ACCESS_TIME_NS = 100;
  localparam int SELECT_ACCESS_TIME_NS = 100;
  localparam int OUTPUT_ACCESS_TIME_NS = 50;
  localparam int SELECT_FLOAT_NS = 50;
  localparam int OUTPUT_FLOAT_NS = 40;
  localparam int WRITE_PULSE_NS = 80;
  localparam int ADDRESS_HOLD_NS = 10;
  localparam int WRITE_DATA_SETUP_NS = 50;
  localparam int WRITE_DATA_HOLD_NS = 5;
  localparam int POWER_UP_RECOVERY_MS = 1;
  // Least times round up to whole cycles.
  localparam int CYC_CYCLE = (CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_ACCESS_RAW = (ADDRESS_ACCESS_TIME_NS > SELECT_ACCESS_TIME_NS) ?
    ADDRESS_ACCESS_TIME_NS : SELECT_ACCESS_TIME_NS;
  localparam int CYC_ACCESS = ((CYC_ACCESS_RAW > OUTPUT_ACCESS_TIME_NS ? CYC_ACCESS_RAW :
    OUTPUT_ACCESS_TIME_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLOAT_RAW = SELECT_FLOAT_NS > OUTPUT_FLOAT_NS ? SELECT_FLOAT_NS : OUTPUT_FLOAT_NS;
  localparam int CYC_FLOAT = (FLOAT_RAW * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_PULSE_RAW = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_SETUP = (WRITE_DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_PULSE = CYC_PULSE_RAW > CYC_SETUP ? CYC_PULSE_RAW : CYC_SETUP;
  localparam int CYC_ADDR_HOLD = (ADDRESS_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_DATA_HOLD = (WRITE_DATA_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_RECOVERY = (POWER_UP_RECOVERY_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 20;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bbs_req_type;

  typedef struct packed {
    logic selectN;
    logic outputEnableN;
    logic writeStrobeN;
  } bbs_ctl_type;
endpackage : bbs_pkg

//--- hw/bbs_sync.sv
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module bbs_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] stage1_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1_q <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule : bbs_sync
`default_nettype wire

//--- hw/bbs_host.sv
// Host controller that drives a battery-backed 8K x 8 asynchronous SRAM through its pins.
// Assumes the SRAM pins are wired directly; data pins are split into in, out and enable.
`timescale 1ns/1ps
`default_nettype none
module bbs_host #(
  parameter int RECOVERY_CYCLES = bbs_pkg::CYC_RECOVERY
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reqValid,
  input wire bbs_pkg::bbs_req_type req,
  output logic reqReady,
  output logic rspValid,
  output logic [bbs_pkg::DATA_W-1:0] rspData,
  input wire logic supplyOk,
  output logic [bbs_pkg::ADDR_W-1:0] addressLines,
  output bbs_pkg::bbs_ctl_type pinCtl,
  input wire logic [bbs_pkg::DATA_W-1:0] dataPinsIn,
  output logic [bbs_pkg::DATA_W-1:0] dataPinsOut,
  output logic dataPinsOe_b
);
  typedef enum logic [2:0] {ST_RECOVER, ST_IDLE, ST_READ, ST_FLOAT, ST_WRITE, ST_WHOLD, ST_GAP} bbs_state_type;

  // ------------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------------
  logic [bbs_pkg::DATA_W:0] syncOut;
  bbs_sync #(.W(bbs_pkg::DATA_W + 1)) uSync (
    .clk(clk),
    .rst_b(rst_b),
    .asyncIn({supplyOk, dataPinsIn}),
    .syncOut(syncOut)
  );
  logic supplyOkS;
  assign supplyOkS = syncOut[bbs_pkg::DATA_W];

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  bbs_state_type state_q;
  logic [bbs_pkg::CNT_W-1:0] cnt_q;
  logic [bbs_pkg::CNT_W-1:0] cyc_q;

  function automatic logic [bbs_pkg::CNT_W-1:0] cyc(input int n);
    cyc = bbs_pkg::CNT_W'(n);
  endfunction : cyc

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_RECOVER;
      cnt_q <= '0;
      cyc_q <= '0;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= '0;
      addressLines <= '0;
      pinCtl <= '{selectN: 1'b1, outputEnableN: 1'b1, writeStrobeN: 1'b1};
      dataPinsOut <= '0;
      dataPinsOe_b <= 1'b1;
    end
    else
    begin
      rspValid <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
      cyc_q <= cyc_q + 1'b1;
      if (!supplyOkS)
      begin
        // Any supply loss abandons the access; the device is deselected and the recovery wait restarts.
        state_q <= ST_RECOVER;
        cnt_q <= '0;
        reqReady <= 1'b0;
        pinCtl <= '{selectN: 1'b1, outputEnableN: 1'b1, writeStrobeN: 1'b1};
        dataPinsOe_b <= 1'b1;
      end
      else
      begin
        case (state_q)
          ST_RECOVER:
          begin
            if (cnt_q >= cyc(RECOVERY_CYCLES) - 1'b1)
            begin
              state_q <= ST_IDLE;
              reqReady <= 1'b1;
            end
          end
          ST_IDLE:
          begin
            if (reqValid)
            begin
              reqReady <= 1'b0;
              addressLines <= req.addr;
              cnt_q <= '0;
              cyc_q <= '0;
              if (req.write)
              begin
                // Select and strobe fall together so the device never drives the bus.
                state_q <= ST_WRITE;
                dataPinsOut <= req.wdata;
                dataPinsOe_b <= 1'b0;
                pinCtl <= '{selectN: 1'b0, outputEnableN: 1'b1, writeStrobeN: 1'b0};
              end
              else
              begin
                state_q <= ST_READ;
                pinCtl <= '{selectN: 1'b0, outputEnableN: 1'b0, writeStrobeN: 1'b1};
              end
            end
          end
          ST_READ:
          begin
            // Sampling waits past the access time plus the two synchroniser stages.
            if (cnt_q >= cyc(bbs_pkg::CYC_ACCESS + 2))
            begin
              rspData <= syncOut[bbs_pkg::DATA_W-1:0];
              rspValid <= 1'b1;
              pinCtl <= '{selectN: 1'b1, outputEnableN: 1'b1, writeStrobeN: 1'b1};
              state_q <= ST_FLOAT;
              cnt_q <= '0;
            end
          end
          ST_FLOAT:
          begin
            if (cnt_q >= cyc(bbs_pkg::CYC_FLOAT) - 1'b1 && cyc_q >= cyc(bbs_pkg::CYC_CYCLE) - 1'b1)
            begin
              state_q <= ST_IDLE;
              reqReady <= 1'b1;
            end
          end
          ST_WRITE:
          begin
            if (cnt_q >= cyc(bbs_pkg::CYC_PULSE) - 1'b1)
            begin
              pinCtl <= '{selectN: 1'b1, outputEnableN: 1'b1, writeStrobeN: 1'b1};
              state_q <= ST_WHOLD;
              cnt_q <= '0;
            end
          end
          ST_WHOLD:
          begin
            if (cnt_q >= cyc(bbs_pkg::CYC_DATA_HOLD) - 1'b1)
            begin
              dataPinsOe_b <= 1'b1;
              state_q <= ST_GAP;
              cnt_q <= '0;
            end
          end
          ST_GAP:
          begin
            if (cnt_q >= cyc(bbs_pkg::CYC_ADDR_HOLD) && cyc_q >= cyc(bbs_pkg::CYC_CYCLE) - 1'b1)
            begin
              state_q <= ST_IDLE;
              reqReady <= 1'b1;
            end
          end
          default:
          begin
            state_q <= ST_RECOVER;
            cnt_q <= '0;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic [bbs_pkg::CNT_W-1:0] lowCnt_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      lowCnt_q <= '0;
    else if (!pinCtl.writeStrobeN)
      lowCnt_q <= lowCnt_q + 1'b1;
    else
      lowCnt_q <= '0;
  end

  write_oe_high_a: assert property (@(posedge clk) disable iff (!rst_b)
    !pinCtl.writeStrobeN |-> pinCtl.outputEnableN)
    else $error("Output enable low during a write.");

  strobe_pulse_width_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(pinCtl.writeStrobeN) && supplyOkS |-> lowCnt_q >= bbs_pkg::CNT_W'(bbs_pkg::CYC_PULSE))
    else $error("Write strobe pulse too short.");

  addr_stable_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!pinCtl.writeStrobeN && $past(!pinCtl.writeStrobeN)) |-> $stable(addressLines))
    else $error("Address moved during a write.");

  data_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(pinCtl.writeStrobeN) && supplyOkS |-> !dataPinsOe_b && $stable(dataPinsOut))
    else $error("Write data not held after write end.");

  supply_deselect_a: assert property (@(posedge clk) disable iff (!rst_b)
    !supplyOkS |=> pinCtl.selectN && pinCtl.writeStrobeN && dataPinsOe_b)
    else $error("Device not deselected on supply loss.");

  recovery_select_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_RECOVER |-> pinCtl.selectN)
    else $error("Select low during recovery.");

  write_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(pinCtl.writeStrobeN) && supplyOkS |-> pinCtl.selectN [*3])
    else $error("New cycle too soon after write.");

  read_ctl_a: assert property (@(posedge clk) disable iff (!rst_b)
    rspValid |-> $past(!pinCtl.selectN && pinCtl.writeStrobeN && !pinCtl.outputEnableN))
    else $error("Read sampled outside read mode.");
endmodule : bbs_host
`default_nettype wire

//--- tb/bbs_sram_model.sv
// Behavioural model of the battery-backed 8K x 8 SRAM as seen at its pins.
// Assumes the host clock only to pace the floating-bus pattern and to sample write ends.
`timescale 1ns/1ps
`default_nettype none
module bbs_sram_model #(
  parameter int ACCESS_NS = bbs_pkg::ADDRESS_ACCESS_TIME_NS
) (
  input wire logic clk,
  input wire logic supplyOk,
  input wire logic [bbs_pkg::ADDR_W-1:0] addressLines,
  input wire bbs_pkg::bbs_ctl_type pinCtl,
  input wire logic [bbs_pkg::DATA_W-1:0] dataPinsOut,
  input wire logic dataPinsOe_b,
  output logic [bbs_pkg::DATA_W-1:0] dataPinsIn
);
  logic [bbs_pkg::DATA_W-1:0] mem [0:8191];
  logic [bbs_pkg::DATA_W-1:0] lastQ = 8'h00;
  int unsigned accessSeq = 0;
  int unsigned settledSeq;
  logic reading;
  logic writing;
  logic writingQ = 1'b0;
  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Supply loss deselects at once, well inside the allowed protection delay.
  assign reading = supplyOk && !pinCtl.selectN
    && !pinCtl.outputEnableN && pinCtl.writeStrobeN;
  // Every address or mode change bumps a sequence number, and data count as valid only once the
  // delayed copy has caught up, so a repeated access to the same byte still waits the full time.
  always @(addressLines or reading)
    accessSeq = accessSeq + 1;
  assign #(ACCESS_NS) settledSeq = accessSeq;
  // A released bus shows a pattern that changes every cycle, never the last value.
  always_comb
  begin
    if (!dataPinsOe_b)
      dataPinsIn = dataPinsOut;
    else if (reading && settledSeq === accessSeq)
      dataPinsIn = mem[addressLines];
    else
      dataPinsIn = ~lastQ;
  end
  // ---------------------------------------------------------------
  // Write path
  // ---------------------------------------------------------------
  assign writing = supplyOk && !pinCtl.selectN && !pinCtl.writeStrobeN;
  always @(posedge clk)
  begin
    lastQ <= dataPinsIn;
    writingQ <= writing;
    // Contents survive supply loss, as they would on battery.
    if (writingQ && !writing && supplyOk)
      mem[addressLines] <= dataPinsIn;
  end
endmodule : bbs_sram_model
`default_nettype wire

//--- tb/tb.sv
// Testbench for the SRAM host port: corner and random reads and writes, supply loss and recovery.
// Assumes the pin model in bbs_sram_model.sv and a shortened recovery count.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb;
  localparam int REC = 8;
  logic clk, rst_b, reqValid, reqReady, rspValid, supplyOk, dataPinsOe_b;
  bbs_pkg::bbs_req_type req;
  bbs_pkg::bbs_ctl_type pinCtl;
  logic [7:0] rspData, dataPinsIn, dataPinsOut;
  logic [12:0] addressLines;
  logic [7:0] shadow [0:8191];
  int miscompares, checked;
  bbs_host #(.RECOVERY_CYCLES(REC)) dut_u (.clk(clk), .rst_b(rst_b), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .supplyOk(supplyOk),
    .addressLines(addressLines), .pinCtl(pinCtl), .dataPinsIn(dataPinsIn),
    .dataPinsOut(dataPinsOut), .dataPinsOe_b(dataPinsOe_b));
  bbs_sram_model mem_u (.clk(clk), .supplyOk(supplyOk), .addressLines(addressLines), .pinCtl(pinCtl),
    .dataPinsOut(dataPinsOut), .dataPinsOe_b(dataPinsOe_b), .dataPinsIn(dataPinsIn));
  // ---------------------------------------------------------------
  // Request tasks
  // ---------------------------------------------------------------
  // Access time, two synchroniser stages and the registered answer.
  function automatic int readLatency();
    readLatency = bbs_pkg::CYC_ACCESS + 3;
  endfunction : readLatency
  task automatic take(input logic wr, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    // A request that is never accepted counts against the run.
    if (n >= 2000)
      miscompares++;
    req = '{write: wr, addr: a, wdata: d};
    reqValid = 1'b1;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
  endtask : take
  task automatic access(input logic wr, input logic [12:0] a, input logic [7:0] d);
    int n;
    take(wr, a, d);
    if (wr)
    begin
      repeat (4) @(posedge clk);
      #1;
      `CHK("wrCtl", 3'b010, pinCtl)
      `CHK("wrAddr", a, addressLines)
      `CHK("wrOe", 1'b0, dataPinsOe_b)
      shadow[a] = d;
    end
    else
    begin
      n = 0;
      while (rspValid !== 1'b1 && n < 100)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      `CHK("rdData", shadow[a], rspData)
      `CHK("rdLatency", readLatency(), n)
    end
  endtask : access
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // About sixty accesses of twenty-seven (write) to forty-two (read) cycles each fit well inside this span.
  initial
  begin
    #(4 * 20000);
    miscompares++;
    conclude();
  end
  initial
  begin
    logic [12:0] a;
    rst_b = 1'b0;
    reqValid = 1'b0;
    req = '0;
    supplyOk = 1'b1;
    miscompares = 0;
    checked = 0;
    void'($urandom(32'hB7A98873));
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < REC; i++)
    begin
      @(posedge clk);
      #1;
      `CHK("recovery", 1'b0, reqReady)
    end
    access(1'b1, 13'h0000, 8'hA5);
    access(1'b1, 13'h1FFF, 8'h5A);
    access(1'b0, 13'h0000, 8'h00);
    access(1'b0, 13'h1FFF, 8'h00);
    for (int i = 1; i < 8; i++)
      access(1'b1, 13'(i * 13'h0401), 8'($urandom));
    // A small address set forces overwrites and back-to-back reads of one byte.
    repeat (40)
    begin
      a = 13'($urandom_range(0, 7)) * 13'h0401;
      access(1'($urandom_range(0, 1)), a, 8'($urandom));
    end
    // Supply loss in the middle of a write to an otherwise unused byte.
    take(1'b1, 13'h1555, 8'h3C);
    repeat (6) @(posedge clk);
    #1;
    supplyOk = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    `CHK("lossCtl", 3'b111, pinCtl)
    `CHK("lossOe", 1'b1, dataPinsOe_b)
    `CHK("lossReady", 1'b0, reqReady)
    repeat (20) @(posedge clk);
    #1;
    supplyOk = 1'b1;
    for (int i = 0; i < REC; i++)
    begin
      @(posedge clk);
      #1;
      `CHK("reRecovery", 1'b0, reqReady)
      `CHK("reSelect", 1'b1, pinCtl.selectN)
    end
    for (int i = 0; i < 8; i++)
      access(1'b0, 13'(i * 13'h0401), 8'h00);
    conclude();
  end
endmodule : tb
`default_nettype wire
